// *** logic/omc_pkg.sv ***
`default_nettype none
package omc_pkg;
	// Command codes of the paged registers.
	localparam logic [7:0] CMD_OPERATION   = 8'h01;
	localparam logic [7:0] CMD_NOMINAL     = 8'h21;
	localparam logic [7:0] CMD_MARGIN_HIGH = 8'h25;
	localparam logic [7:0] CMD_MARGIN_LOW  = 8'h26;
	// Page values.
	localparam logic [7:0] PAGE_A    = 8'h00;
	localparam logic [7:0] PAGE_B    = 8'h01;
	localparam logic [7:0] PAGE_BOTH = 8'hFF;
	// Operation field positions and codes.
	localparam int OP_ON_BIT     = 7;
	localparam int OP_MARGIN_LSB = 2;
	localparam logic [7:0] OP_WRITE_MASK = 8'hBF;
	localparam logic [3:0] MARGIN_NONE    = 4'h0;
	localparam logic [3:0] MARGIN_LOW_IGN = 4'h5;
	localparam logic [3:0] MARGIN_LOW_ACT = 4'h6;
	localparam logic [3:0] MARGIN_HI_IGN  = 4'h9;
	localparam logic [3:0] MARGIN_HI_ACT  = 4'hA;
	// Reset values.
	localparam logic [7:0] OP_RESET      = 8'h00;
	localparam logic [7:0] NOMINAL_RESET = 8'h00;
	localparam logic [7:0] MARGIN_RESET  = 8'h00;
	// Margin state of one channel.
	typedef enum logic [2:0] {
		OMC_NONE = 3'b001,
		OMC_LOW  = 3'b010,
		OMC_HIGH = 3'b100
	} omc_margin_t;
endpackage : omc_pkg
`default_nettype wire

// *** logic/omc_chan_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface omc_chan_if;
	logic       wr_op;
	logic       wr_nom;
	logic       wr_lo;
	logic       wr_hi;
	logic [7:0] wdata;
	logic [7:0] op;
	logic [7:0] nominal;
	logic [7:0] margin_lo;
	logic [7:0] margin_hi;
	logic [7:0] target;
	logic       act_on_fault;
	logic       max_warn;
	modport bank (input wr_op, wr_nom, wr_lo, wr_hi, wdata,
		output op, nominal, margin_lo, margin_hi, target, act_on_fault,
		max_warn);
	modport ctrl (output wr_op, wr_nom, wr_lo, wr_hi, wdata,
		input op, nominal, margin_lo, margin_hi, target, act_on_fault,
		max_warn);
endinterface : omc_chan_if
`default_nettype wire

// *** logic/omc_chan.sv ***
`timescale 1ns/1ps
`default_nettype none
module omc_chan (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [7:0] vout_max,
	omc_chan_if.bank        bus
);
	logic [7:0]  op;
	logic [7:0]  nominal;
	logic [7:0]  margin_lo;
	logic [7:0]  margin_hi;
	logic [7:0]  target;
	logic        act;
	logic        warn;
	omc_pkg::omc_margin_t state;
	logic [7:0]  next_op;
	logic [7:0]  next_nominal;
	logic [7:0]  next_margin_lo;
	logic [7:0]  next_margin_hi;
	logic [7:0]  next_target;
	logic        next_act;
	logic        next_warn;
	omc_pkg::omc_margin_t next_state;
	logic [3:0]  code;

	always_comb begin
		next_op        = op;
		next_nominal   = nominal;
		next_margin_lo = margin_lo;
		next_margin_hi = margin_hi;
		next_state     = state;
		next_act       = act;
		if (bus.wr_op)
			next_op = bus.wdata & omc_pkg::OP_WRITE_MASK;
		if (bus.wr_nom)
			next_nominal = (bus.wdata > vout_max) ? vout_max
				: bus.wdata;
		if (bus.wr_lo)
			next_margin_lo = bus.wdata;
		if (bus.wr_hi)
			next_margin_hi = bus.wdata;
		code = next_op[omc_pkg::OP_MARGIN_LSB +: 4];
		unique case (code)
			omc_pkg::MARGIN_NONE: begin
				next_state = omc_pkg::OMC_NONE;
				next_act   = 1'b0;
			end
			omc_pkg::MARGIN_LOW_IGN, omc_pkg::MARGIN_LOW_ACT: begin
				next_state = omc_pkg::OMC_LOW;
				next_act   = (code == omc_pkg::MARGIN_LOW_ACT);
			end
			omc_pkg::MARGIN_HI_IGN, omc_pkg::MARGIN_HI_ACT: begin
				next_state = omc_pkg::OMC_HIGH;
				next_act   = (code == omc_pkg::MARGIN_HI_ACT);
			end
			default: begin
				// Invalid codes keep the previous target and handling.
				next_state = state;
				next_act   = act;
			end
		endcase
		unique case (next_state)
			omc_pkg::OMC_LOW:  next_target = next_margin_lo;
			omc_pkg::OMC_HIGH: next_target = next_margin_hi;
			default:  next_target = next_nominal;
		endcase
		// Warn when an acting margin load sits above the nominal point.
		next_warn = next_act && (next_target > next_nominal);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			op        <= omc_pkg::OP_RESET;
			nominal   <= omc_pkg::NOMINAL_RESET;
			margin_lo <= omc_pkg::MARGIN_RESET;
			margin_hi <= omc_pkg::MARGIN_RESET;
			target    <= omc_pkg::NOMINAL_RESET;
			act       <= 1'b0;
			warn      <= 1'b0;
			state     <= omc_pkg::OMC_NONE;
		end else begin
			op        <= next_op;
			nominal   <= next_nominal;
			margin_lo <= next_margin_lo;
			margin_hi <= next_margin_hi;
			target    <= next_target;
			act       <= next_act;
			warn      <= next_warn;
			state     <= next_state;
		end
	end

	assign bus.op           = op;
	assign bus.nominal      = nominal;
	assign bus.margin_lo    = margin_lo;
	assign bus.margin_hi    = margin_hi;
	assign bus.target       = target;
	assign bus.act_on_fault = act;
	assign bus.max_warn     = warn;
endmodule : omc_chan
`default_nettype wire

// *** logic/omc_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Operation bit 7 turns conversion on or off for the paged channel(s).
// - Conversion also needs input above UVLO and enable pins where configured.
// - Margin code 0000b makes the nominal setpoint the target.
// - Codes 0101b and 0110b pick margin-low, ignoring or acting on faults.
// - Codes 1001b and 1010b pick margin-high, ignoring or acting on faults.
// - Operation bits 1:0 are writable; host writes them as 00b.
// - Acting margin above nominal may raise the maximum-output warning.
// - Nominal setpoint holds the VID code of the active page.
// - Nominal setpoint never exceeds the configured maximum output value.
// - Page 00h is channel A, 01h channel B, FFh both.
// - Setpoint bits 15:8 are read-only zero; low byte read/write.
// - Margin-low register holds the target while margin state is low.
// - Margin-high register holds the target while margin state is high.
// - Output moves to each new target at the configured slew rate.
// - Operation acts only when on/off configuration respects it.
module omc_regs #(
	parameter int NCH = 2
) (
	input  wire logic           clk,
	input  wire logic           rst_b,
	input  wire logic [7:0]     page,
	input  wire logic           cmd_wr,
	input  wire logic           cmd_rd,
	input  wire logic [7:0]     cmd_code,
	input  wire logic [15:0]    cmd_wdata,
	output logic      [15:0]    cmd_rdata,
	output logic                cmd_ack,
	output logic                cmd_err,
	input  wire logic [7:0]     vout_max,
	input  wire logic [NCH-1:0] respect_cmd,
	input  wire logic [NCH-1:0] require_pin,
	input  wire logic [NCH-1:0] enable_pin,
	input  wire logic [NCH-1:0] vin_ok,
	input  wire logic [7:0]     slew_step,
	output logic      [NCH-1:0] convert_en,
	output logic      [NCH*8-1:0] vid_out,
	output logic      [NCH-1:0] act_on_fault,
	output logic      [NCH-1:0] max_warn
);
	// The page decode and the readback know channels A and B only, so
	// any other channel count is refused when the design is built.
	generate
		if (NCH != 2) begin : gen_bad_nch
			$error("omc_regs serves exactly two channels");
		end
	endgenerate

	logic [NCH-1:0] sel;
	logic           known;
	// Readback byte of each channel for the addressed command.
	logic [7:0]     rd_byte [NCH];
	logic [7:0]     pick;
	logic [15:0]    next_rdata;
	logic           next_ack;
	logic           next_err;

	// Page FFh addresses both channels; any unlisted page reaches none.
	always_comb begin
		sel[0] = (page == omc_pkg::PAGE_A) || (page == omc_pkg::PAGE_BOTH);
		sel[1] = (page == omc_pkg::PAGE_B) || (page == omc_pkg::PAGE_BOTH);
	end

	// Only the four commands of this bank are answered without an error.
	always_comb begin
		unique case (cmd_code)
			omc_pkg::CMD_OPERATION,
			omc_pkg::CMD_NOMINAL,
			omc_pkg::CMD_MARGIN_LOW,
			omc_pkg::CMD_MARGIN_HIGH: known = 1'b1;
			default:                  known = 1'b0;
		endcase
	end

	// Each channel keeps its own register set; the page decides which of
	// them see a write, and the shared page writes both in one cycle.
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : gen_ch
			omc_chan_if cif ();
			logic [7:0] vid;
			logic [7:0] next_vid;
			logic       next_convert;
			logic [7:0] diff;

			// Only a selected channel sees a write strobe, and the data
			// byte is the low byte of the word.
			always_comb begin
				cif.wdata  = cmd_wdata[7:0];
				cif.wr_op  = 1'b0;
				cif.wr_nom = 1'b0;
				cif.wr_lo  = 1'b0;
				cif.wr_hi  = 1'b0;
				if (cmd_wr && sel[g]) begin
					unique case (cmd_code)
						omc_pkg::CMD_OPERATION:   cif.wr_op  = 1'b1;
						omc_pkg::CMD_NOMINAL:     cif.wr_nom = 1'b1;
						omc_pkg::CMD_MARGIN_LOW:  cif.wr_lo  = 1'b1;
						omc_pkg::CMD_MARGIN_HIGH: cif.wr_hi  = 1'b1;
						default:                  cif.wr_op  = 1'b0;
					endcase
				end
			end

			omc_chan u_chan (
				.clk      (clk),
				.rst_b    (rst_b),
				.vout_max (vout_max),
				.bus      (cif.bank)
			);

			// A channel converts only when every enabling condition holds;
			// the on bit counts only where the channel honours it.
			always_comb begin
				next_convert = vin_ok[g];
				if (require_pin[g] && !enable_pin[g])
					next_convert = 1'b0;
				if (respect_cmd[g] && !cif.op[omc_pkg::OP_ON_BIT])
					next_convert = 1'b0;
			end

			// The enable is registered so that it never glitches on a pin.
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b)
					convert_en[g] <= 1'b0;
				else
					convert_en[g] <= next_convert;
			end

			always_comb begin
				unique case (cmd_code)
					omc_pkg::CMD_OPERATION:   rd_byte[g] = cif.op;
					omc_pkg::CMD_NOMINAL:     rd_byte[g] = cif.nominal;
					omc_pkg::CMD_MARGIN_LOW:  rd_byte[g] = cif.margin_lo;
					omc_pkg::CMD_MARGIN_HIGH: rd_byte[g] = cif.margin_hi;
					default:                  rd_byte[g] = 8'h00;
				endcase
			end

			// Step the output VID toward the target, limited by the slew
			// step, so that a new target never lands as one large jump.
			always_comb begin
				if (vid > cif.target)
					diff = vid - cif.target;
				else
					diff = cif.target - vid;
				if (diff <= slew_step)
					next_vid = cif.target;
				else if (vid < cif.target)
					next_vid = vid + slew_step;
				else
					next_vid = vid - slew_step;
			end

			// Reset starts every channel at VID code zero.
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b)
					vid <= omc_pkg::NOMINAL_RESET;
				else
					vid <= next_vid;
			end

			// Outputs leave straight from flip-flops of this channel.
			assign vid_out[g*8 +: 8] = vid;
			assign act_on_fault[g]   = cif.act_on_fault;
			assign max_warn[g]       = cif.max_warn;
		end
	endgenerate

	// Every request is answered one clock later; a page that selects no
	// channel or an unknown command is refused without storing.
	always_comb begin
		next_ack = cmd_wr || cmd_rd;
		next_err = 1'b0;
		if (next_ack && (!known || (sel == '0)))
			next_err = 1'b1;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_ack <= 1'b0;
			cmd_err <= 1'b0;
		end else begin
			cmd_ack <= next_ack;
			cmd_err <= next_err;
		end
	end

	// A read at the shared page answers from the lowest selected
	// channel, which is channel A.
	always_comb begin
		pick = 8'h00;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (sel[i])
				pick = rd_byte[i];
		end
	end

	// Upper byte of every register reads as zero.
	always_comb begin
		next_rdata = 16'h0000;
		if (cmd_rd && known)
			next_rdata = {8'h00, pick};
	end

	// Read data stands for one cycle and is zero otherwise.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			cmd_rdata <= 16'h0000;
		else
			cmd_rdata <= next_rdata;
	end
endmodule : omc_regs
`default_nettype wire

// *** bench/omc_regs_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module omc_regs_assertions #(
	parameter int NCH = 2
) (
	input wire logic             clk,
	input wire logic             rst_b,
	input wire logic [7:0]       page,
	input wire logic             cmd_wr,
	input wire logic             cmd_rd,
	input wire logic [15:0]      cmd_rdata,
	input wire logic             cmd_ack,
	input wire logic             cmd_err,
	input wire logic [NCH-1:0]   require_pin,
	input wire logic [NCH-1:0]   enable_pin,
	input wire logic [NCH-1:0]   vin_ok,
	input wire logic [7:0]       slew_step,
	input wire logic [NCH-1:0]   convert_en,
	input wire logic [NCH*8-1:0] vid_out,
	input wire logic [NCH-1:0]   act_on_fault,
	input wire logic [NCH-1:0]   max_warn
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_hi; cmd_ack |-> cmd_rdata[15:8] == 8'h00; endproperty
	a_hi: assert property (p_hi) else $error("high byte set");
	property p_rd0; !$past(cmd_rd) |-> cmd_rdata == 16'h0000; endproperty
	a_rd0: assert property (p_rd0) else $error("stray rdata");
	property p_page; (cmd_wr || cmd_rd) && !(page inside {8'h00, 8'h01,
		8'hFF}) |=> cmd_ack && cmd_err; endproperty
	a_page: assert property (p_page) else $error("bad page");
	property p_vin; convert_en[0] |-> $past(vin_ok[0]); endproperty
	a_vin: assert property (p_vin) else $error("on below UVLO");
	property p_pin; convert_en[1] |-> $past(enable_pin[1] || !require_pin[1]);
	endproperty
	a_pin: assert property (p_pin) else $error("on without pin");
	property p_warn; max_warn[0] |-> act_on_fault[0]; endproperty
	a_warn: assert property (p_warn) else $error("warn not acting");
	property p_frz; $past(slew_step) == 8'h00 |-> $stable(vid_out); endproperty
	a_frz: assert property (p_frz) else $error("vid moved");
	property p_step; vid_out[7:0] > $past(vid_out[7:0]) |->
		vid_out[7:0] - $past(vid_out[7:0]) <= $past(slew_step); endproperty
	a_step: assert property (p_step) else $error("step too big");
	property p_ack; (cmd_wr || cmd_rd) |=> cmd_ack; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_idle; !(cmd_wr || cmd_rd) |=> !cmd_ack && !cmd_err;
	endproperty
	a_idle: assert property (p_idle) else $error("stray ack");
endmodule : omc_regs_assertions
bind omc_regs omc_regs_assertions #(.NCH(NCH)) chk (.*);
`default_nettype wire

// *** bench/omc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module omc_host (
	input wire logic  clk,
	input wire logic  [15:0] cmd_rdata,
	input wire logic  cmd_ack,
	input wire logic  cmd_err,
	output var logic  [7:0] page = 8'h00,
	output var logic  cmd_wr = 1'b0,
	output var logic  cmd_rd = 1'b0,
	output var logic  [7:0] cmd_code = 8'h00,
	output var logic  [15:0] cmd_wdata = 16'h0000
);
	task automatic xfer(input logic w, input logic [7:0] p, c,
		input logic [15:0] d, output logic [15:0] q, output logic a, e);
		@(posedge clk);
		page <= p;
		cmd_wr <= w;
		cmd_rd <= !w;
		cmd_code <= c;
		cmd_wdata <= (c == omc_pkg::CMD_OPERATION) ?
			{8'h00, d[7:2], 2'b00} : d;
		@(posedge clk);
		cmd_wr <= 1'b0;
		cmd_rd <= 1'b0;
		cmd_wdata <= ~d;
		#1;
		q = cmd_rdata;
		a = cmd_ack;
		e = cmd_err;
	endtask : xfer
endmodule : omc_host
`default_nettype wire

// *** bench/output_margin_command_regs_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module output_margin_command_regs_bench;
	logic clk = 1'b0, rst_b = 1'b0, cmd_wr, cmd_rd, cmd_ack, cmd_err;
	logic [7:0] page, cmd_code, vout_max = 8'h50, slew_step = 8'h08;
	logic [15:0] cmd_wdata, cmd_rdata, vid_out, q;
	logic [1:0] respect_cmd = 2'b11, require_pin = 2'b00;
	logic [1:0] enable_pin = 2'b00, vin_ok = 2'b11;
	logic [1:0] convert_en, act_on_fault, max_warn;
	logic a, e;
	int fail_count = 0, comparisons = 0, cycles = 0;
	omc_regs uut (.clk(clk), .rst_b(rst_b), .page(page), .cmd_wr(cmd_wr),
		.cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
		.cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_err(cmd_err),
		.vout_max(vout_max), .respect_cmd(respect_cmd),
		.require_pin(require_pin), .enable_pin(enable_pin), .vin_ok(vin_ok),
		.slew_step(slew_step), .convert_en(convert_en), .vid_out(vid_out),
		.act_on_fault(act_on_fault), .max_warn(max_warn));
	omc_host host (.clk(clk), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
		.cmd_err(cmd_err), .page(page), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
	always #25 clk = ~clk;
	task chk(input string n, input logic [15:0] x, g);
		comparisons++;
		if (g !== x) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, x, g);
		end
	endtask : chk
	task wr(input logic [7:0] p, c, input logic [15:0] d, input logic ee);
		host.xfer(1'b1, p, c, d, q, a, e);
		chk("ack", 16'(1'b1), 16'(a));
		chk("err", 16'(ee), 16'(e));
	endtask : wr
	task rd(input logic [7:0] p, c, input logic [15:0] x);
		host.xfer(1'b0, p, c, 16'h0000, q, a, e);
		chk("rdata", x, q);
	endtask : rd
	task t_page;
		rd(omc_pkg::PAGE_A, omc_pkg::CMD_MARGIN_HIGH, 16'h0000);
		wr(omc_pkg::PAGE_A, omc_pkg::CMD_NOMINAL, 16'hFF30, 1'b0);
		wr(omc_pkg::PAGE_B, omc_pkg::CMD_NOMINAL, 16'h0020, 1'b0);
		wr(omc_pkg::PAGE_BOTH, omc_pkg::CMD_MARGIN_LOW, 16'h0010, 1'b0);
		rd(omc_pkg::PAGE_A, omc_pkg::CMD_NOMINAL, 16'h0030);
		rd(omc_pkg::PAGE_B, omc_pkg::CMD_NOMINAL, 16'h0020);
		rd(omc_pkg::PAGE_A, omc_pkg::CMD_MARGIN_LOW, 16'h0010);
		rd(omc_pkg::PAGE_B, omc_pkg::CMD_MARGIN_LOW, 16'h0010);
		wr(8'h02, omc_pkg::CMD_NOMINAL, 16'h0055, 1'b1);
		wr(omc_pkg::PAGE_A, 8'h30, 16'h0012, 1'b1);
		rd(omc_pkg::PAGE_A, 8'h30, 16'h0000);
		wr(omc_pkg::PAGE_A, omc_pkg::CMD_NOMINAL, 16'h0070, 1'b0);
		rd(omc_pkg::PAGE_A, omc_pkg::CMD_NOMINAL, 16'h0050);
		wr(omc_pkg::PAGE_A, omc_pkg::CMD_NOMINAL, 16'h0030, 1'b0);
		wr(omc_pkg::PAGE_A, omc_pkg::CMD_MARGIN_LOW, 16'h0020, 1'b0);
		wr(omc_pkg::PAGE_A, omc_pkg::CMD_MARGIN_HIGH, 16'h0040, 1'b0);
		$display("page test done");
	endtask : t_page
	task t_margin;
		logic [7:0] op [6] = '{8'h80, 8'h94, 8'h98, 8'hA4, 8'hA8, 8'h8C};
		logic [7:0] v [6] = '{8'h30, 8'h20, 8'h20, 8'h40, 8'h40, 8'h40};
		logic [1:0] f [6] = '{2'b00, 2'b00, 2'b10, 2'b00, 2'b11, 2'b11};
		for (int i = 0; i < 6; i++) begin
			wr(omc_pkg::PAGE_A, omc_pkg::CMD_OPERATION, {8'h00, op[i]}, 1'b0);
			repeat (10) @(posedge clk);
			chk("vid", 16'(v[i]), 16'(vid_out[7:0]));
			chk("act", 16'(f[i][1]), 16'(act_on_fault[0]));
			chk("warn", 16'(f[i][0]), 16'(max_warn[0]));
			rd(omc_pkg::PAGE_A, omc_pkg::CMD_OPERATION, {8'h00, op[i]});
		end
		chk("vid b", 16'h0020, 16'(vid_out[15:8]));
		wr(omc_pkg::PAGE_B, omc_pkg::CMD_MARGIN_HIGH, 16'h0030, 1'b0);
		wr(omc_pkg::PAGE_B, omc_pkg::CMD_OPERATION, 16'h00A8, 1'b0);
		repeat (10) @(posedge clk);
		chk("vid b hi", 16'h0030, 16'(vid_out[15:8]));
		chk("act b", 16'h0001, 16'(act_on_fault[1]));
		chk("warn b", 16'h0001, 16'(max_warn[1]));
		@(posedge clk) slew_step <= 8'h00;
		wr(omc_pkg::PAGE_A, omc_pkg::CMD_OPERATION, 16'h0080, 1'b0);
		repeat (10) @(posedge clk);
		chk("frozen", 16'h0040, 16'(vid_out[7:0]));
		@(posedge clk) slew_step <= 8'h08;
		$display("margin test done");
	endtask : t_margin
	task t_onoff;
		// Each case: respect, require, pin, vin, on bit, expected enable.
		logic [5:0] cs [6] = '{6'b100111, 6'b100010, 6'b110110, 6'b111111,
			6'b111100, 6'b011101};
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			respect_cmd <= {2{cs[i][5]}};
			require_pin <= {2{cs[i][4]}};
			enable_pin <= {2{cs[i][3]}};
			vin_ok <= {2{cs[i][2]}};
			wr(omc_pkg::PAGE_BOTH, omc_pkg::CMD_OPERATION, {8'h00, cs[i][1],
				7'h00}, 1'b0);
			repeat (3) @(posedge clk);
			chk("conv", 16'({2{cs[i][0]}}), 16'(convert_en));
		end
		$display("on off test done");
	endtask : t_onoff
	task t_reset;
		@(posedge clk) rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		chk("vid rst", 16'h0000, vid_out);
		chk("conv rst", 16'h0000, 16'(convert_en));
		chk("warn rst", 16'h0000, 16'(max_warn));
		@(posedge clk) rst_b <= 1'b1;
		rd(omc_pkg::PAGE_A, omc_pkg::CMD_NOMINAL, 16'h0000);
		rd(omc_pkg::PAGE_A, omc_pkg::CMD_OPERATION, 16'h0000);
		$display("reset test done");
	endtask : t_reset
	task test_done;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			test_done;
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		t_page;
		t_margin;
		t_onoff;
		t_reset;
		test_done;
	end
endmodule : output_margin_command_regs_bench
`default_nettype wire
